// ---- logic/dbgcx_pkg.sv ----
package dbgcx_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] DBGCX_CCX_IDX = 4'ha;
  localparam logic [3:0] DBGCX_FX_IDX = 4'hb;
  localparam logic [3:0] DBGCX_MODE_IDX = 4'hf;
  localparam int DBGCX_IDX_LSB = 2;
  localparam int DBGCX_AW = 6;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CCX_DIR_EN_BIT = 7;
  localparam int CCX_DIR_VAL_BIT = 6;
  localparam int CCX_PAGED_BIT = 5;
  localparam int CCX_B16_BIT = 0;
  localparam int FX_PAGED_BIT = 7;
  localparam int FX_B16_BIT = 0;
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_BEGIN_BIT = 1;
  localparam int MODE_LOOP_BIT = 2;
  localparam logic [7:0] CCX_RESET = 8'h00;
  localparam logic [7:0] FX_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CCX_IMPL_MASK = 8'he1;
  localparam logic [7:0] MODE_IMPL_MASK = 8'h07;

  // ----------------------------------------------------------------
  // address geometry
  // ----------------------------------------------------------------
  localparam int PAGE_W = 3;
  localparam int PAGE_LOW_W = 14;
  localparam int CPU_AW = 16;
  localparam int CORE_AW = 17;
  localparam int XINFO_W = 2;
  localparam int DEPTH_DEF = 8;

  // storing state of the trace run
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_STORE,
    ST_DONE
  } dbgcx_state_t;

endpackage

// ---- logic/dbgcx_buf_if.sv ----
`timescale 1ns/1ps
interface dbgcx_buf_if #(parameter int DEPTH = 8, parameter int XW = 2);
  logic wr_en;
  logic [$clog2(DEPTH)-1:0] wr_idx;
  logic [XW-1:0] wr_data;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [XW-1:0] rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ---- logic/dbgcx_xmem.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// per-word extended info store for the trace buffer
// ------------------------------------------------------------------
module dbgcx_xmem #(
  parameter int DEPTH = 8,
  parameter int XW = 2
) (
  input wire logic mclk, // bus clock
  dbgcx_buf_if.mem bus // write and read ports
);

  logic [XW-1:0] mem_r [DEPTH];
  logic [XW-1:0] rd_data_r;

  // no reset on the array: contents must survive an end-run reset anyway
  always_ff @(posedge mclk) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_idx] <= bus.wr_data;
    end
  end

  // read data registered, one cycle after the index
  always_ff @(posedge mclk) begin
    rd_data_r <= mem_r[bus.rd_idx];
  end

  assign bus.rd_data = rd_data_r;

endmodule // dbgcx_xmem

// ---- logic/dbgcx_core.sv ----
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - with the direction enable clear, comparator C ignores read versus write.
// - with the direction enable set, a value of 0 matches writes and 1 matches reads.
// - the page qualifier requires the paged indication to equal it for any match.
// - a paged access forms the core address from the page bits and CPU address 13..0.
// - an unpaged access forms the core address from the CPU address with bit 16 zero, or from a linear pointer.
// - comparator C requires core address bit 16 to equal its stored bit 16.
// - an end-run reset (enabled, end trigger) leaves both extension registers unchanged.
// - the paged flag of the info register is the paged indication sampled at a change-of-flow capture, zero for an event-only word.
// - a paged captured word holds the page bits on top and CPU address 13..0 below.
// - an unpaged captured word is event-only data or a CPU address with bit 16 zero.
// - bit 0 of the info register is bit 16 of the captured core address of the current word.
// - the begin/end setting decides whether a trigger starts or ends storing.
// - in single-loop mode a change-of-flow address not matching comparator C is captured and loaded into it.
module dbgcx_core
  import dbgcx_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input wire logic mclk, // bus clock, 20 MHz
  input wire logic reset, // async power-on reset
  input wire logic [DBGCX_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic cpu_reset, // system reset pulse
  input wire logic cpu_valid, // core bus cycle valid
  input wire logic cpu_read, // 1 read, 0 write
  input wire logic [CPU_AW-1:0] cpu_addr, // CPU address
  input wire logic ppage_sel, // paged access indication
  input wire logic [PAGE_W-1:0] ppage, // page register bits
  input wire logic linear_valid, // linear pointer access
  input wire logic [CORE_AW-1:0] linear_addr, // linear pointer value
  input wire logic cof_valid, // change of flow on this cycle
  input wire logic evt_valid, // event-only capture
  input wire logic arm, // start a trace run
  input wire logic disarm, // stop a trace run
  input wire logic [CPU_AW-1:0] cmp_c_addr, // comparator C low address
  input wire logic [$clog2(DEPTH)-1:0] cur_word_idx, // current buffer word
  output logic cmp_c_match, // registered match
  output logic storing, // storing into buffer
  output logic cap_valid, // capture strobe
  output logic [CORE_AW-1:0] cap_addr, // captured address
  output logic cap_paged, // captured paged flag
  output logic cmp_c_load, // reload comparator C
  output logic [CPU_AW-1:0] cmp_c_load_addr // new comparator C address
);

  localparam int IW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic [7:0] ccx_r;
  logic [7:0] ccx_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic fx_valid_r;

  // decode shared by the read and write paths
  function automatic logic hit_reg(input logic [DBGCX_AW-1:0] a, input logic [3:0] idx);
    hit_reg = (a[DBGCX_AW-1:DBGCX_IDX_LSB] == idx) && (a[DBGCX_IDX_LSB-1:0] == '0);
  endfunction

  wire req = avs_read | avs_write;
  wire wr_take = avs_write & ack_r & avs_byteenable[0];
  wire wr_ccx = wr_take & hit_reg(avs_address, DBGCX_CCX_IDX);
  wire wr_mode = wr_take & hit_reg(avs_address, DBGCX_MODE_IDX);
  wire rd_ccx = hit_reg(avs_address, DBGCX_CCX_IDX);
  wire rd_fx = hit_reg(avs_address, DBGCX_FX_IDX);
  wire rd_mode = hit_reg(avs_address, DBGCX_MODE_IDX);

  // one wait state: data is latched on the first edge, released on the second
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // mode bits and end-run reset
  // ----------------------------------------------------------------
  wire dbg_en = mode_r[MODE_EN_BIT];
  wire trig_begin = mode_r[MODE_BEGIN_BIT];
  wire single_loop_capture_mode = mode_r[MODE_LOOP_BIT];
  // end-run: the run ends with a reset while enabled in end-trigger mode
  wire end_run = dbg_en & ~trig_begin;
  wire soft_clr = cpu_reset & ~end_run;

  // ----------------------------------------------------------------
  // core address formation
  // ----------------------------------------------------------------
  logic [CORE_AW-1:0] core_addr;
  logic [CORE_AW-1:0] prog_addr;
  wire [CORE_AW-1:0] paged_addr = {ppage, cpu_addr[PAGE_LOW_W-1:0]};
  wire [CORE_AW-1:0] flat_addr = {1'b0, cpu_addr};
  assign core_addr = ppage_sel ? paged_addr : (linear_valid ? linear_addr : flat_addr);
  // change-of-flow addresses are program addresses, never linear pointers
  assign prog_addr = ppage_sel ? paged_addr : flat_addr;

  // ----------------------------------------------------------------
  // comparator C qualification
  // ----------------------------------------------------------------
  wire dir_en = ccx_r[CCX_DIR_EN_BIT];
  wire dir_val = ccx_r[CCX_DIR_VAL_BIT];
  wire paged_q = ccx_r[CCX_PAGED_BIT];
  wire b16_q = ccx_r[CCX_B16_BIT];
  wire dir_ok = ~dir_en | (cpu_read == dir_val);
  wire page_ok = ppage_sel == paged_q;
  wire b16_ok = core_addr[CORE_AW-1] == b16_q;
  wire low_ok = core_addr[CPU_AW-1:0] == cmp_c_addr;
  wire addr_hit = low_ok & b16_ok & page_ok;
  wire cmp_hit = cpu_valid & addr_hit & dir_ok;

  // ----------------------------------------------------------------
  // storing state
  // ----------------------------------------------------------------
  dbgcx_state_t state_r;
  dbgcx_state_t state_nxt;

  // begin mode waits for the trigger, end mode stores until it
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (arm & dbg_en) begin
          state_nxt = trig_begin ? ST_WAIT : ST_STORE;
        end
      end
      ST_WAIT: begin
        if (cmp_hit) begin
          state_nxt = ST_STORE;
        end
      end
      ST_STORE: begin
        if (cmp_hit & ~trig_begin) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (disarm | ~dbg_en) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else if (cpu_reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign storing = (state_r == ST_STORE);

  // ----------------------------------------------------------------
  // capture decision
  // ----------------------------------------------------------------
  // single-loop mode drops a repeat of the last loop address
  wire cof_take = storing & cof_valid;
  wire loop_skip = single_loop_capture_mode & cmp_hit;
  wire cap_cof = cof_take & ~loop_skip;
  wire cap_evt = storing & evt_valid & ~cof_valid;
  wire cap_any = cap_cof | cap_evt;
  wire loop_load = cap_cof & single_loop_capture_mode;

  // ----------------------------------------------------------------
  // extension register and mode register
  // ----------------------------------------------------------------
  // a hardware reload beats a software write in the same cycle
  always_comb begin
    ccx_nxt = ccx_r;
    if (wr_ccx) begin
      ccx_nxt = avs_writedata[7:0] & CCX_IMPL_MASK;
    end
    if (loop_load) begin
      ccx_nxt[CCX_PAGED_BIT] = ppage_sel;
      ccx_nxt[CCX_B16_BIT] = prog_addr[CORE_AW-1];
    end
    mode_nxt = wr_mode ? (avs_writedata[7:0] & MODE_IMPL_MASK) : mode_r;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ccx_r <= CCX_RESET;
      mode_r <= MODE_RESET;
    end else if (soft_clr) begin
      ccx_r <= CCX_RESET;
      mode_r <= MODE_RESET;
    end else begin
      ccx_r <= ccx_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // capture outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cap_valid <= 1'b0;
      cap_addr <= '0;
      cap_paged <= 1'b0;
      cmp_c_load <= 1'b0;
      cmp_c_load_addr <= '0;
      cmp_c_match <= 1'b0;
    end else begin
      cap_valid <= cap_any;
      cap_addr <= cap_cof ? prog_addr : '0;
      cap_paged <= cap_cof & ppage_sel;
      cmp_c_load <= loop_load;
      cmp_c_load_addr <= loop_load ? prog_addr[CPU_AW-1:0] : cmp_c_load_addr;
      cmp_c_match <= cmp_hit;
    end
  end

  // ----------------------------------------------------------------
  // per-word extended info store
  // ----------------------------------------------------------------
  logic [IW-1:0] wptr_r;
  dbgcx_buf_if #(.DEPTH(DEPTH), .XW(XINFO_W)) xbuf ();

  assign xbuf.wr_en = cap_any;
  assign xbuf.wr_idx = wptr_r;
  assign xbuf.wr_data = {cap_cof & ppage_sel, cap_cof & prog_addr[CORE_AW-1]};
  assign xbuf.rd_idx = cur_word_idx;

  dbgcx_xmem #(.DEPTH(DEPTH), .XW(XINFO_W)) u_xmem (
    .mclk(mclk),
    .bus(xbuf)
  );

  // pointer and valid survive an end-run reset with the stored words
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wptr_r <= '0;
      fx_valid_r <= 1'b0;
    end else if (soft_clr) begin
      wptr_r <= '0;
      fx_valid_r <= 1'b0;
    end else if (cap_any) begin
      wptr_r <= IW'(wptr_r + 1'b1);
      fx_valid_r <= 1'b1;
    end
  end

  // info register reads zero until a word has been captured
  logic [7:0] fx_view;
  always_comb begin
    fx_view = FX_RESET;
    if (fx_valid_r) begin
      fx_view[FX_PAGED_BIT] = xbuf.rd_data[1];
      fx_view[FX_B16_BIT] = xbuf.rd_data[0];
    end
  end

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (rd_ccx) begin
      rdata_nxt[7:0] = ccx_r & CCX_IMPL_MASK;
    end else if (rd_fx) begin
      rdata_nxt[7:0] = fx_view;
    end else if (rd_mode) begin
      rdata_nxt[7:0] = mode_r;
    end
  end

  // latched on the first edge of a read so it stands at the release edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_loop_miss;
    storing && cof_valid && single_loop_capture_mode && !cmp_hit;
  endsequence

  sequence s_reload;
    cmp_c_load && cap_valid;
  endsequence

  AST_DIR_IGNORED: assert property (@(posedge mclk) disable iff (reset)
    (cpu_valid && !dir_en && addr_hit) |=> cmp_c_match)
    else $error("direction not ignored with enable clear");

  AST_DIR_VALUE: assert property (@(posedge mclk) disable iff (reset)
    (cmp_hit && dir_en) |-> (cpu_read == dir_val))
    else $error("direction value mismatch on match");

  AST_PAGE_QUAL: assert property (@(posedge mclk) disable iff (reset)
    cmp_c_match |-> ($past(ppage_sel) == $past(paged_q)))
    else $error("match without page qualifier agreement");

  AST_PAGED_ADDR: assert property (@(posedge mclk) disable iff (reset)
    ppage_sel |-> (core_addr == {ppage, cpu_addr[PAGE_LOW_W-1:0]}))
    else $error("paged core address wrong");

  AST_FLAT_ADDR: assert property (@(posedge mclk) disable iff (reset)
    (!ppage_sel && !linear_valid) |-> (core_addr[CORE_AW-1] == 1'b0))
    else $error("unpaged address bit 16 not zero");

  AST_B16_CMP: assert property (@(posedge mclk) disable iff (reset)
    cmp_c_match |-> ($past(core_addr[CORE_AW-1]) == $past(b16_q)))
    else $error("bit 16 compare broken");

  AST_END_RUN_HOLD: assert property (@(posedge mclk) disable iff (reset)
    (cpu_reset && end_run && !wr_ccx && !loop_load) |=> $stable(ccx_r))
    else $error("extension lost on end-run reset");

  AST_PAGED_CAPTURE: assert property (@(posedge mclk) disable iff (reset)
    (cap_cof && ppage_sel) |=> (cap_valid && cap_paged))
    else $error("paged flag not captured");

  AST_PAGED_WORD: assert property (@(posedge mclk) disable iff (reset)
    (cap_valid && cap_paged) |-> (cap_addr == $past(paged_addr)))
    else $error("paged word layout wrong");

  AST_UNPAGED_WORD: assert property (@(posedge mclk) disable iff (reset)
    (cap_valid && !cap_paged) |-> (cap_addr[CORE_AW-1] == 1'b0))
    else $error("unpaged word has bit 16 set");

  AST_BEGIN_TRIG: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ST_WAIT && cmp_hit && !disarm && dbg_en && !cpu_reset) |=> storing)
    else $error("begin trigger did not start storing");

  AST_LOOP_RELOAD: assert property (@(posedge mclk) disable iff (reset)
    s_loop_miss |=> s_reload)
    else $error("loop miss not reloaded into comparator");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (reset)
    (avs_read && !avs_waitrequest && (rd_ccx || rd_fx)) |->
    (avs_readdata[4:1] == 4'h0 && avs_readdata[31:8] == 24'h000000 && (rd_ccx || avs_readdata[6:5] == 2'b00)))
    else $error("reserved bits read nonzero");

endmodule // dbgcx_core

// ---- sim/dbgcx_cpu_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// core bus model: one cycle per call, scrambled when released
// ------------------------------------------------------------------
module dbgcx_cpu_model (
  input wire logic mclk, // bus clock
  output logic cpu_valid, // cycle valid
  output logic cpu_read, // 1 read, 0 write
  output logic [15:0] cpu_addr, // cpu address
  output logic ppage_sel, // paged indication
  output logic [2:0] ppage, // page bits
  output logic cof_valid // change of flow
);
  initial begin
    cpu_valid = 1'b0;
    cpu_read = 1'b0;
    cpu_addr = 16'h0000;
    ppage_sel = 1'b0;
    ppage = 3'h0;
    cof_valid = 1'b0;
  end
  // inverse of last direction, address and page values after release, valid and change of flow cleared, so stale bits never look valid
  task automatic cyc(input logic rd, input logic [15:0] a, input logic pg, input logic [2:0] p, input logic change_of_flow);
    @(posedge mclk);
    cpu_valid <= 1'b1;
    cpu_read <= rd;
    cpu_addr <= a;
    ppage_sel <= pg;
    ppage <= p;
    cof_valid <= change_of_flow;
    @(posedge mclk);
    cpu_valid <= 1'b0;
    cpu_read <= ~rd;
    cpu_addr <= ~a;
    ppage_sel <= ~pg;
    ppage <= ~p;
    cof_valid <= 1'b0;
  endtask
endmodule // dbgcx_cpu_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module testbench;
  import dbgcx_pkg::*;
  logic mclk, reset, avs_read, avs_write, cpu_reset, arm, disarm;
  logic evt_valid, linear_valid;
  logic [16:0] linear_addr;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata;
  logic [15:0] cmp_c_addr;
  logic [2:0] cur_word_idx;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, cpu_valid, cpu_read, ppage_sel, cof_valid;
  wire logic [15:0] cpu_addr, cmp_c_load_addr;
  wire logic [2:0] ppage;
  wire logic cmp_c_match, storing, cap_valid, cap_paged, cmp_c_load;
  wire logic [16:0] cap_addr;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  // ----------------------------------------------------------------
  // clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  dbgcx_cpu_model cpu (.mclk(mclk), .cpu_valid(cpu_valid), .cpu_read(cpu_read), .cpu_addr(cpu_addr),
    .ppage_sel(ppage_sel), .ppage(ppage), .cof_valid(cof_valid));
  dbgcx_core #(.DEPTH(8)) dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_reset(cpu_reset), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
    .cpu_addr(cpu_addr), .ppage_sel(ppage_sel), .ppage(ppage), .linear_valid(linear_valid),
    .linear_addr(linear_addr),
    .cof_valid(cof_valid), .evt_valid(evt_valid), .arm(arm), .disarm(disarm), .cmp_c_addr(cmp_c_addr),
    .cur_word_idx(cur_word_idx), .cmp_c_match(cmp_c_match), .storing(storing), .cap_valid(cap_valid),
    .cap_addr(cap_addr), .cap_paged(cap_paged), .cmp_c_load(cmp_c_load), .cmp_c_load_addr(cmp_c_load_addr));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // waitrequest and readdata read before this edge's updates land
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pulse_arm(input logic a);
    @(posedge mclk);
    if (a) arm <= 1'b1;
    else disarm <= 1'b1;
    @(posedge mclk);
    arm <= 1'b0;
    disarm <= 1'b0;
  endtask
  task automatic wait_st(input logic e);
    int i;
    for (i = 0; i < 4 && storing !== e; i++) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    bus(0, 6'h28, 8'h00);
    `CHK("ccx reset", 32'h0, rd)
    bus(0, 6'h2c, 8'h00);
    `CHK("fx reset", 32'h0, rd)
    bus(1, 6'h2c, 8'hff);
    bus(0, 6'h2c, 8'h00);
    `CHK("fx ro", 32'h0, rd)
    bus(1, 6'h28, 8'hff);
    bus(0, 6'h28, 8'h00);
    `CHK("ccx mask", 32'he1, rd)
    bus(0, 6'h00, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    $display("test regs done");
  endtask
  task automatic t_match();
    logic [10:0] cs [10] = '{11'h001, 11'h005, 11'h404, 11'h201, 11'h605, 11'h600,
      11'h10f, 11'h106, 11'h002, 11'h008};
    int i;
    cmp_c_addr <= 16'hb234;
    for (i = 0; i < 10; i++) begin
      bus(1, 6'h28, cs[i][10:3]);
      cpu.cyc(cs[i][2], 16'hb234, cs[i][1], 3'b110, 1'b0);
      #1;
      `CHK("match", cs[i][0], cmp_c_match)
    end
    // linear pointer with bit 16 set against a stored bit 16 of 1
    @(posedge mclk) linear_valid <= 1'b1;
    linear_addr <= 17'h1b234;
    cpu.cyc(0, 16'hb234, 0, 3'b000, 0);
    #1;
    `CHK("linear match", 1'b1, cmp_c_match)
    @(posedge mclk) linear_valid <= 1'b0;
    $display("test match done");
  endtask
  task automatic t_capture();
    cmp_c_addr <= 16'h0f0f;
    bus(1, 6'h28, 8'h00);
    bus(1, 6'h3c, 8'h01);
    pulse_arm(1);
    wait_st(1);
    `CHK("end storing", 1'b1, storing)
    cpu.cyc(0, 16'hb234, 1, 3'b110, 1);
    #1;
    `CHK("cap valid", 1'b1, cap_valid)
    `CHK("cap addr paged", 17'h1b234, cap_addr)
    `CHK("cap paged", 1'b1, cap_paged)
    cpu.cyc(1, 16'h4567, 0, 3'b111, 1);
    #1;
    `CHK("cap addr flat", 17'h04567, cap_addr)
    `CHK("cap flat", 1'b0, cap_paged)
    @(posedge mclk) evt_valid <= 1'b1;
    @(posedge mclk) evt_valid <= 1'b0;
    #1;
    `CHK("evt valid", 1'b1, cap_valid)
    `CHK("evt addr", 17'h00000, cap_addr)
    `CHK("evt paged", 1'b0, cap_paged)
    @(posedge mclk) cur_word_idx <= 3'h0;
    repeat (2) @(posedge mclk);
    bus(0, 6'h2c, 8'h00);
    `CHK("fx word0", 32'h81, rd)
    @(posedge mclk) cur_word_idx <= 3'h1;
    repeat (2) @(posedge mclk);
    bus(0, 6'h2c, 8'h00);
    `CHK("fx word1", 32'h00, rd)
    cmp_c_addr <= 16'h4567;
    cpu.cyc(1, 16'h4567, 0, 3'b000, 0);
    wait_st(0);
    `CHK("end trigger", 1'b0, storing)
    $display("test capture done");
  endtask
  task automatic t_begin();
    pulse_arm(0);
    bus(1, 6'h3c, 8'h03);
    pulse_arm(1);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("begin wait", 1'b0, storing)
    cpu.cyc(1, 16'h4567, 0, 3'b000, 0);
    wait_st(1);
    `CHK("begin trigger", 1'b1, storing)
    pulse_arm(0);
    $display("test begin done");
  endtask
  task automatic t_endrun();
    @(posedge mclk) cur_word_idx <= 3'h0;
    bus(1, 6'h28, 8'he1);
    bus(1, 6'h3c, 8'h01);
    @(posedge mclk) cpu_reset <= 1'b1;
    @(posedge mclk) cpu_reset <= 1'b0;
    bus(0, 6'h28, 8'h00);
    `CHK("ccx kept", 32'he1, rd)
    bus(0, 6'h2c, 8'h00);
    `CHK("fx kept", 32'h81, rd)
    bus(1, 6'h3c, 8'h03);
    @(posedge mclk) cpu_reset <= 1'b1;
    @(posedge mclk) cpu_reset <= 1'b0;
    bus(0, 6'h28, 8'h00);
    `CHK("ccx cleared", 32'h00, rd)
    bus(0, 6'h2c, 8'h00);
    `CHK("fx cleared", 32'h00, rd)
    $display("test endrun done");
  endtask
  task automatic t_loop();
    cmp_c_addr <= 16'h1234;
    bus(1, 6'h3c, 8'h05);
    bus(1, 6'h28, 8'h00);
    pulse_arm(1);
    wait_st(1);
    cpu.cyc(0, 16'hb234, 1, 3'b110, 1);
    #1;
    `CHK("loop cap", 1'b1, cap_valid)
    `CHK("loop load", 1'b1, cmp_c_load)
    `CHK("loop addr", 16'hb234, cmp_c_load_addr)
    bus(0, 6'h28, 8'h00);
    `CHK("loop ccx", 32'h21, rd)
    cmp_c_addr <= 16'hb234;
    cpu.cyc(0, 16'hb234, 1, 3'b110, 1);
    #1;
    `CHK("loop drop", 1'b0, cap_valid)
    pulse_arm(0);
    $display("test loop done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    cpu_reset = 1'b0;
    evt_valid = 1'b0;
    linear_valid = 1'b0;
    linear_addr = 17'h00000;
    arm = 1'b0;
    disarm = 1'b0;
    cmp_c_addr = 16'h0000;
    cur_word_idx = 3'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_match();
    t_capture();
    t_begin();
    t_endrun();
    t_loop();
    give_verdict();
  end
endmodule // testbench
